// *** shared/sfs_pkg.sv ***
// ======================================================================
// constants and types for the fault and status logic
package sfs_pkg;
	// ==================================================================
	// clock and interval timing
	localparam int CLK_MHZ        = 40;
	localparam int RESERVE_LOW_US = 1000; // reserve_low_reset_interval
	localparam int CAPTEST_US     = 1000; // captest_reset_interval
	localparam int TIMEOUT_US     = 1000; // frame_timeout_interval
	localparam int RESERVE_LOW_CYC = RESERVE_LOW_US * CLK_MHZ;
	localparam int CAPTEST_CYC     = CAPTEST_US * CLK_MHZ;
	localparam int TIMEOUT_CYC     = TIMEOUT_US * CLK_MHZ;
	localparam int CNT_W           = 24;

	// ==================================================================
	// repeated-reset channels
	localparam int NUM_CH     = 3;
	localparam int CH_RESERVE = 0;
	localparam int CH_CAPTEST = 1;
	localparam int CH_TIMEOUT = 2;

	// ==================================================================
	// lockout and synchroniser layout
	localparam logic [1:0] LOCKOUT_CMDS = 2'h2;
	localparam int SY_RESERVE = 0;
	localparam int SY_CAPTEST = 1;
	localparam int SY_BUS     = 2;
	localparam int SY_UV      = 3;
	localparam int SY_W       = 4;

	// ==================================================================
	// enumerations
	typedef enum logic [1:0] {
		CK_OTHER   = 2'b00,
		CK_ST_EN   = 2'b01,
		CK_ST_DIS  = 2'b10,
		CK_CLEAR   = 2'b11
	} sfs_cmd_kind_type;

	typedef enum logic [1:0] {
		SEL_NORMAL   = 2'b00,
		SEL_ZERO     = 2'b01,
		SEL_SELFTEST = 2'b10
	} sfs_resp_sel_type;

	typedef enum logic [1:0] {
		ST_OFF    = 2'b00,
		ST_ON     = 2'b01,
		ST_LOCKED = 2'b10
	} sfs_st_state_type;
endpackage : sfs_pkg

// *** shared/sfs_tmr_if.sv ***
`timescale 1ns/1ps
// ======================================================================
// link between the fault logic and one repeat-interval timer
interface sfs_tmr_if;
	logic run;    // condition present, timer counts
	logic expire; // one-cycle pulse at end of each interval
	modport ctrl  (output run, input expire);
	modport timer (input run, output expire);
endinterface : sfs_tmr_if

// *** hw/sfs_timer.sv ***
`timescale 1ns/1ps
// ======================================================================
// interval timer: pulses every LIMIT cycles while run stays high
module sfs_timer #(
	parameter int LIMIT = 40000,
	parameter int CW    = 24
) (
	input  wire logic clk,
	input  wire logic rst_n,
	sfs_tmr_if.timer  tmr
);
	logic [CW-1:0] cnt;
	logic          at_end;

	// terminal count detect
	assign at_end     = (cnt == CW'(LIMIT - 1));
	assign tmr.expire = tmr.run && at_end;

	// count restarts when condition drops or interval ends
	always_ff @(posedge clk) begin
		if (!rst_n || !tmr.run || at_end) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + CW'(1);
		end
	end
endmodule : sfs_timer

// *** hw/sfs_fault_status.sv ***
`timescale 1ns/1ps
// ======================================================================
// Overview of operation
// (RL1) reserve node low too long: repeated reset
// (RL2) capacitor test failure: repeated reset while present
// (RL3) bus line low too long: repeated reset
// (RL4) no command answered while reset repeats
// (RL5) master re-initializes device after exception clears
// (RL6) factory array fault, self-test off: error, zero short
// (RL7) factory array fault, self-test on: self-test long
// (RL8) user array fault, self-test off: error, zero short
// (RL9) user array fault, self-test on: self-test long
// (RL10) self-test on: error, flag set, self-test data
// (RL11) two disable commands enter self-test lockout
// (RL12) lockout ignores enable, flag stays clear
// (RL13) clear command or reset leaves lockout
// (RL14) self-test flag follows self-test circuitry
// (RL15) error flag reports internal device error
// (RL16) other addressed command restarts disable count
module sfs_fault_status #(
	parameter int RESERVE_LOW_CYCLES = sfs_pkg::RESERVE_LOW_CYC,
	parameter int CAPTEST_CYCLES     = sfs_pkg::CAPTEST_CYC,
	parameter int TIMEOUT_CYCLES     = sfs_pkg::TIMEOUT_CYC
) (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      reserve_node_low,
	input  wire logic                      captest_fail,
	input  wire logic                      bus_line_low,
	input  wire logic                      supply_uv,
	input  wire logic                      factory_crc_fail,
	input  wire logic                      factory_lock,
	input  wire logic                      user_mismatch,
	input  wire logic                      user_lock,
	input  wire logic                      cmd_valid,
	input  wire logic                      cmd_addr_match,
	input  wire sfs_pkg::sfs_cmd_kind_type cmd_kind,
	output logic                           device_reset,
	output logic                           exception_hold,
	output logic                           resp_enable,
	output logic                           selftest_drive,
	output logic                           lockout,
	output logic                           error_flag,
	output logic                           selftest_active_flag,
	output logic                           low_reserve_flag,
	output sfs_pkg::sfs_resp_sel_type      short_resp_sel,
	output sfs_pkg::sfs_resp_sel_type      long_resp_sel
);
	import sfs_pkg::*;

	// ==================================================================
	// input synchronisers
	logic [SY_W-1:0] sync1;
	logic [SY_W-1:0] sync2;
	logic            reserve_low;
	logic            cap_fail;
	logic            bus_low;
	logic            uv;

	// two flip-flops before any logic sees the analog flags
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {supply_uv, bus_line_low, captest_fail,
				reserve_node_low};
			sync2 <= sync1;
		end
	end

	assign reserve_low = sync2[SY_RESERVE];
	assign cap_fail    = sync2[SY_CAPTEST];
	assign bus_low     = sync2[SY_BUS];
	assign uv          = sync2[SY_UV];

	// ==================================================================
	// repeated-reset channels
	sfs_tmr_if       tmr [NUM_CH] ();
	logic [NUM_CH-1:0] run;
	logic [NUM_CH-1:0] expire;
	logic [NUM_CH-1:0] held;
	logic [NUM_CH-1:0] next_held;

	// conditions; supply under-voltage stops reserve and bus repeats
	assign run[CH_RESERVE] = reserve_low && !uv; // RL1
	assign run[CH_CAPTEST] = cap_fail;           // RL2
	assign run[CH_TIMEOUT] = bus_low && !uv;     // RL3

	// one timer per channel, each with its own interval
	generate
		for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
			localparam int LIM = (i == CH_RESERVE) ? RESERVE_LOW_CYCLES :
				(i == CH_CAPTEST) ? CAPTEST_CYCLES : TIMEOUT_CYCLES;
			assign tmr[i].run = run[i];
			assign expire[i]  = tmr[i].expire;
			// held from first expiry until the condition goes away
			assign next_held[i] = run[i] && (held[i] || expire[i]);
			sfs_timer #(
				.LIMIT (LIM),
				.CW    (CNT_W)
			) u_tmr (
				.clk   (clk),
				.rst_n (rst_n),
				.tmr   (tmr[i])
			);
		end
	endgenerate

	// reset pulse each interval, hold level for the whole exception
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			held         <= '0;
			device_reset <= 1'b0;
		end else begin
			held         <= next_held;
			device_reset <= |expire; // RL1 RL2 RL3
		end
	end

	assign exception_hold = |held;
	assign resp_enable    = !exception_hold && !device_reset; // RL4

	// ==================================================================
	// command intake and self-test state
	sfs_st_state_type state;
	sfs_st_state_type next_state;
	logic [1:0]       dis_cnt;
	logic [1:0]       next_dis_cnt;
	logic             cmd_take;
	logic             take_en;
	logic             take_dis;
	logic             take_clr;
	logic             lock_hit;

	// only addressed commands count, none while reset repeats
	assign cmd_take = cmd_valid && cmd_addr_match && !exception_hold; // RL4
	assign take_en  = cmd_take && (cmd_kind == CK_ST_EN);
	assign take_dis = cmd_take && (cmd_kind == CK_ST_DIS);
	assign take_clr = cmd_take && (cmd_kind == CK_CLEAR);
	assign lock_hit = take_dis && (dis_cnt == LOCKOUT_CMDS - 2'h1); // RL11

	// consecutive disable counter
	always_comb begin
		next_dis_cnt = dis_cnt;
		if (device_reset) begin
			next_dis_cnt = 2'h0;
		end else if (take_dis) begin
			if (dis_cnt != LOCKOUT_CMDS) begin
				next_dis_cnt = dis_cnt + 2'h1; // RL11
			end
		end else if (cmd_take) begin
			next_dis_cnt = 2'h0; // RL16
		end
	end

	// self-test state machine
	always_comb begin
		next_state = state;
		case (state)
			ST_OFF: begin
				if (take_en) begin
					next_state = ST_ON;
				end
			end
			ST_ON: begin
				if (take_dis || take_clr) begin
					next_state = ST_OFF;
				end
			end
			ST_LOCKED: begin
				if (take_clr) begin
					next_state = ST_OFF; // RL13
				end
			end
			default: begin
				next_state = ST_OFF;
			end
		endcase
		if (lock_hit) begin
			next_state = ST_LOCKED; // RL11
		end
		if (device_reset) begin
			next_state = ST_OFF; // RL13
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state   <= ST_OFF;
			dis_cnt <= 2'h0;
		end else begin
			state   <= next_state;
			dis_cnt <= next_dis_cnt;
		end
	end

	assign selftest_drive = (state == ST_ON);     // RL10 RL11 RL12
	assign lockout        = (state == ST_LOCKED);

	// ==================================================================
	// status flags and response data selection
	logic             fault;
	logic             next_error;
	sfs_resp_sel_type next_short;
	sfs_resp_sel_type next_long;

	// stored-array integrity faults only count when locked
	assign fault = (factory_crc_fail && factory_lock) ||
		(user_mismatch && user_lock); // RL6 RL8
	assign next_error = fault || selftest_drive; // RL15 RL10

	// short: faults force zero, then self-test, then low reserve
	assign next_short = fault ? SEL_ZERO :
		selftest_drive ? SEL_SELFTEST :
		reserve_low ? SEL_ZERO : SEL_NORMAL; // RL6 RL7 RL8 RL9 RL10
	// long: self-test data whenever self-test runs
	assign next_long = selftest_drive ? SEL_SELFTEST
		: SEL_NORMAL; // RL7 RL9 RL10

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			error_flag           <= 1'b0;
			selftest_active_flag <= 1'b0;
			low_reserve_flag     <= 1'b0;
			short_resp_sel       <= SEL_NORMAL;
			long_resp_sel        <= SEL_NORMAL;
		end else begin
			error_flag           <= next_error;     // RL15
			selftest_active_flag <= selftest_drive; // RL14 RL12
			low_reserve_flag     <= reserve_low;
			short_resp_sel       <= next_short;
			long_resp_sel        <= next_long;
		end
	end

	// ==================================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_dis_second;
		lock_hit && !device_reset;
	endsequence

	sequence s_en_locked;
		lockout && take_en && !device_reset && !lock_hit;
	endsequence

	sequence s_stays_locked;
		lockout && !selftest_drive;
	endsequence

	a_reserve_reset: assert property ( // RL1
		expire[CH_RESERVE] |=> device_reset && exception_hold)
		else $error("reserve expiry did not reset");
	a_captest_reset: assert property ( // RL2
		expire[CH_CAPTEST] |=> device_reset && exception_hold)
		else $error("capacitor test expiry did not reset");
	a_timeout_reset: assert property ( // RL3
		expire[CH_TIMEOUT] |=> device_reset && exception_hold)
		else $error("frame timeout did not reset");
	a_hold_release: assert property ( // RL1
		exception_hold && (run == '0) |=> !exception_hold)
		else $error("exception hold outlived its condition");
	a_hold_mute: assert property ( // RL4
		exception_hold |-> !resp_enable && !cmd_take)
		else $error("command answered during exception");
	a_lockout_entry: assert property ( // RL11
		s_dis_second |=> lockout && !selftest_drive)
		else $error("second disable did not lock out");
	a_lockout_enable: assert property ( // RL12
		s_en_locked |=> s_stays_locked ##1 !selftest_active_flag)
		else $error("enable started self-test in lockout");
	a_clear_unlock: assert property ( // RL13
		lockout && (take_clr || device_reset) |=> !lockout)
		else $error("lockout not left on clear or reset");
	a_fault_flags: assert property ( // RL6
		fault |=> error_flag && short_resp_sel == SEL_ZERO)
		else $error("array fault not reported");
	a_selftest_flags: assert property ( // RL10
		selftest_drive |=> error_flag && selftest_active_flag &&
			long_resp_sel == SEL_SELFTEST)
		else $error("self-test flags or data wrong");
	a_count_restart: assert property ( // RL16
		cmd_take && cmd_kind != CK_ST_DIS |=> dis_cnt == 2'h0)
		else $error("disable count not restarted");
	a_user_flags: assert property ( // RL8
		user_mismatch && user_lock |=> error_flag &&
			short_resp_sel == SEL_ZERO)
		else $error("user array fault not reported");
	a_fault_st_long: assert property ( // RL7 RL9
		fault && selftest_drive |=> selftest_active_flag &&
			long_resp_sel == SEL_SELFTEST)
		else $error("array fault lost self-test data");
	a_fault_nost_long: assert property ( // RL6 RL8
		fault && !selftest_drive |=> !selftest_active_flag &&
			long_resp_sel == SEL_NORMAL)
		else $error("array fault changed normal long data");
	a_reset_mute: assert property ( // RL4
		device_reset |-> !resp_enable)
		else $error("command answered during reset pulse");
	a_flag_off: assert property ( // RL14
		!selftest_drive |=> !selftest_active_flag)
		else $error("self-test flag set while self-test off");
endmodule : sfs_fault_status

// *** bench/sfs_master_model.sv ***
`timescale 1ns/1ps
// ======================================================================
// bus master stand-in: sends decoded commands, re-initialises the device
module sfs_master_model (
	input  wire logic                 clk,
	input  wire logic                 exception_hold,
	output logic                      cmd_valid,
	output logic                      cmd_addr_match,
	output sfs_pkg::sfs_cmd_kind_type cmd_kind
);
	import sfs_pkg::*;
	logic was_held = 1'b0;

	// idle lines at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd_addr_match = 1'b0;
		cmd_kind = CK_OTHER;
	end

	// one-cycle command; idle lines show the inverse so nothing is reused
	task automatic send(input sfs_cmd_kind_type k, input logic m);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_addr_match = m;
		cmd_kind = k;
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_addr_match = ~m;
		cmd_kind = sfs_cmd_kind_type'(~k);
	endtask : send

	// a clear command once a held exception lets go
	always @(negedge clk) begin
		if (was_held && !exception_hold) begin
			was_held = 1'b0;
			send(CK_CLEAR, 1'b1);
		end
		was_held = exception_hold;
	end
endmodule : sfs_master_model

// *** bench/tb_sfs_fault_status.sv ***
`timescale 1ns/1ps
// ======================================================================
// self-checking bench for the fault and status logic
module tb_sfs_fault_status;
	import sfs_pkg::*;
	localparam int LIM = 8;
	logic             clk = 1'b0;
	logic             rst_n = 1'b0;
	logic [2:0]       pin = 3'h0; // reserve, captest, bus line
	logic             uv = 1'b0;
	logic [3:0]       flt = 4'h0; // f crc, f lock, u mismatch, u lock
	logic             cv;
	logic             cm;
	sfs_cmd_kind_type ck;
	logic             dr, eh, re, sd, lo, ef, sf, lf;
	sfs_resp_sel_type ss, ls;
	int               fail_count = 0;
	int               samples_checked = 0;
	int               n;

	// 40 MHz clock
	initial forever #12.5 clk = ~clk;

	sfs_fault_status #(.RESERVE_LOW_CYCLES(LIM), .CAPTEST_CYCLES(LIM),
		.TIMEOUT_CYCLES(LIM)) i_dut (
		.clk(clk), .rst_n(rst_n), .reserve_node_low(pin[0]),
		.captest_fail(pin[1]), .bus_line_low(pin[2]), .supply_uv(uv),
		.factory_crc_fail(flt[3]), .factory_lock(flt[2]),
		.user_mismatch(flt[1]), .user_lock(flt[0]), .cmd_valid(cv),
		.cmd_addr_match(cm), .cmd_kind(ck), .device_reset(dr),
		.exception_hold(eh), .resp_enable(re), .selftest_drive(sd),
		.lockout(lo), .error_flag(ef), .selftest_active_flag(sf),
		.low_reserve_flag(lf), .short_resp_sel(ss), .long_resp_sel(ls));

	sfs_master_model i_master (.clk(clk), .exception_hold(eh),
		.cmd_valid(cv), .cmd_addr_match(cm), .cmd_kind(ck));

	// compare and count
	task check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// counts and verdict
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test

	task tick(input int k);
		repeat (k) @(negedge clk);
	endtask : tick

	// command, then let state, flags and selects settle
	task cmd(input sfs_cmd_kind_type k, input logic m);
		i_master.send(k, m);
		tick(3);
	endtask : cmd

	// status flags and response selects
	task flags(input logic [2:0] f, input sfs_resp_sel_type s,
		input sfs_resp_sel_type l);
		check(8'({ef, sf, lf}), 8'(f));
		check(8'(ss), 8'(s));
		check(8'(ls), 8'(l));
		check(8'({ss, ls}), 8'({s, l}));
	endtask : flags

	// bounded wait for a reset pulse
	task wait_rst;
		n = 0;
		while (dr !== 1'b1) begin
			tick(1);
			n++;
			if (n > 40) begin
				fail_count++;
				finish_test;
			end
		end
	endtask : wait_rst

	// hang guard
	initial begin
		tick(20000);
		fail_count++;
		finish_test;
	end

	// main sequence
	initial begin
		tick(12);
		rst_n = 1'b1;
		tick(1);
		check(8'({dr, eh, re, sd, lo}), 8'h04);
		flags(3'b000, SEL_NORMAL, SEL_NORMAL);
		cmd(CK_ST_EN, 1'b1);
		check(8'(sd), 8'h01);
		flags(3'b110, SEL_SELFTEST, SEL_SELFTEST);
		flt = 4'b1100;
		tick(3);
		flags(3'b110, SEL_ZERO, SEL_SELFTEST);
		flt = 4'b0011;
		tick(3);
		flags(3'b110, SEL_ZERO, SEL_SELFTEST);
		cmd(CK_ST_DIS, 1'b1);
		flt = 4'b1100;
		tick(3);
		flags(3'b100, SEL_ZERO, SEL_NORMAL);
		flt = 4'b0011;
		tick(3);
		flags(3'b100, SEL_ZERO, SEL_NORMAL);
		flt = 4'b1010;
		tick(3);
		flags(3'b000, SEL_NORMAL, SEL_NORMAL);
		flt = 4'h0;
		cmd(CK_OTHER, 1'b0);
		cmd(CK_ST_DIS, 1'b1);
		check(8'({sd, lo}), 8'h01);
		flags(3'b000, SEL_NORMAL, SEL_NORMAL);
		cmd(CK_ST_EN, 1'b1);
		check(8'({sd, lo}), 8'h01);
		flags(3'b000, SEL_NORMAL, SEL_NORMAL);
		cmd(CK_CLEAR, 1'b1);
		check(8'(lo), 8'h00);
		cmd(CK_ST_DIS, 1'b1);
		cmd(CK_OTHER, 1'b1);
		cmd(CK_ST_DIS, 1'b1);
		check(8'(lo), 8'h00);
		cmd(CK_ST_DIS, 1'b1);
		check(8'(lo), 8'h01);
		rst_n = 1'b0;
		tick(3);
		rst_n = 1'b1;
		tick(1);
		check(8'(lo), 8'h00);
		// each repeated-reset channel in turn
		for (int ch = 0; ch < 3; ch++) begin
			pin[ch] = 1'b1;
			if (ch == 0) begin
				tick(4);
				check(8'({lf, ss}), 8'({1'b1, SEL_ZERO}));
			end
			wait_rst;
			check(8'({eh, re}), 8'h02);
			n = 1;
			tick(1);
			while (dr !== 1'b1 && n < 40) begin
				tick(1);
				n++;
			end
			check(8'(n), 8'(LIM));
			check(8'({eh, re}), 8'h02);
			// an enable sent while held must be ignored
			cmd(CK_ST_EN, 1'b1);
			check(8'(sd), 8'h00);
			if (ch != 1) begin
				uv = 1'b1;
				tick(5);
				n = 0;
				repeat (LIM + 2) begin
					tick(1);
					if (dr === 1'b1)
						n++;
				end
				check(8'({n[3:0], eh}), 8'h00);
			end
			pin[ch] = 1'b0;
			tick(5);
			uv = 1'b0;
			check(8'({eh, re}), 8'h01);
			tick(6);
		end
		finish_test;
	end
endmodule : tb_sfs_fault_status
